// File: logic/dtrt_map.svh
/*
 * Register addresses, bit positions, reset values and timing counts of the
 * three timer/counters.
 * Assumes it is included by bare name before any module that uses it.
 */
`ifndef DTRT_MAP_SVH
`define DTRT_MAP_SVH

// ==========================================================================
// special function register addresses
`define DTRT_ADDR_TIMER01_CONTROL_REG      8'h88
`define DTRT_ADDR_TIMER01_MODE_REG      8'h89
`define DTRT_ADDR_TL0       8'h8A
`define DTRT_ADDR_TL1       8'h8B
`define DTRT_ADDR_TH0       8'h8C
`define DTRT_ADDR_TH1       8'h8D
`define DTRT_ADDR_TIMER2_CONTROL     8'hC8
`define DTRT_ADDR_RCAPL     8'hCA
`define DTRT_ADDR_RCAPH     8'hCB
`define DTRT_ADDR_TL2       8'hCC
`define DTRT_ADDR_TH2       8'hCD

// ==========================================================================
// reset values
`define DTRT_RST_BYTE       8'h00
`define DTRT_RST_WORD       16'h0000

// ==========================================================================
// timer01_control_reg bit positions
`define DTRT_TIMER01_CONTROL_REG_TF1       7
`define DTRT_TIMER01_CONTROL_REG_TR1       6
`define DTRT_TIMER01_CONTROL_REG_TF0       5
`define DTRT_TIMER01_CONTROL_REG_TR0       4

// ==========================================================================
// timer01_mode_reg: timer 1 nibble base, and positions within a nibble
`define DTRT_TIMER01_MODE_REG_T1_LSB    4
`define DTRT_TIMER01_MODE_REG_GATE      3
`define DTRT_TIMER01_MODE_REG_CT        2
`define DTRT_TIMER01_MODE_REG_MODE_LSB  0

// ==========================================================================
// timing: core clocks per machine cycle
`define DTRT_CLK_PER_MC     12

`endif

// File: logic/dtrt_pkg.sv
/*
 * Types shared by the timer/counter block.
 * Assumes the map header carries every number; this package holds types only.
 */
package dtrt_pkg;

   // ========================================================================
   // timer 0/1 operating modes
   typedef enum logic [1:0] {
      DTRT_M13   = 2'b00,
      DTRT_M16   = 2'b01,
      DTRT_M8R   = 2'b10,
      DTRT_MSPL  = 2'b11
   } dtrt_mode_t;

   // ========================================================================
   // one special function register write from the core
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dtrt_sfr_t;

   // ========================================================================
   // result of one counting step of a high/low byte pair
   typedef struct packed {
      logic [7:0] th;
      logic [7:0] tl;
      logic       ovf;
   } dtrt_cnt_t;

   // ========================================================================
   // timer2_control layout, bit 7 first
   typedef struct packed {
      logic tf2;
      logic timer2_external_flag;
      logic rclk;
      logic tx_clock_select;
      logic timer2_external_enable;
      logic tr2;
      logic timer2_counter_select;
      logic timer2_capture_select;
   } dtrt_timer2_control_t;

endpackage : dtrt_pkg

// File: logic/dtrt_pin_sync.sv
/*
 * Two-flop synchroniser with a falling-edge detector for one pin.
 * Assumes the pin idles high; the edge is read from the second and third flop.
 */
`timescale 1ns/10ps
module dtrt_pin_sync (
   input  logic clk,
   input  logic rstn,
   input  logic pinIn,
   output logic level,
   output logic fall
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } dtrt_sync_st_t;

   dtrt_sync_st_t st_r;
   dtrt_sync_st_t st_nxt;

   // ========================================================================
   // shift chain
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = pinIn;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= 3'b111;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs from the second and third flop only
   assign level = st_r.s2;
   assign fall  = st_r.s3 & ~st_r.s2;

endmodule : dtrt_pin_sync

// File: logic/dtrt_t2.sv
/*
 * Timer 2: 16-bit count, reload/capture pair and its control register.
 * Assumes synchronised one-cycle edge pulses for the count and trigger pins.
 */
`timescale 1ns/10ps
`include "dtrt_map.svh"
module dtrt_t2 (
   input  logic                   clk,
   input  logic                   rstn,
   input  dtrt_pkg::dtrt_sfr_t    sfrReq,
   input  logic                   cntFall,
   input  logic                   trigFall,
   output dtrt_pkg::dtrt_timer2_control_t  ctl,
   output logic [15:0]            count,
   output logic [15:0]            reload,
   output logic                   ovfPulse
);

   typedef struct packed {
      dtrt_pkg::dtrt_timer2_control_t ctl;
      logic [15:0]           cnt;
      logic [15:0]           rcap;
      logic                  ovf;
   } dtrt_t2_st_t;

   dtrt_t2_st_t st_r;
   dtrt_t2_st_t st_nxt;
   logic        baud;
   logic        capMode;
   logic        inc;
   logic        extEv;

   // ========================================================================
   // counting, reload, capture and flags
   always_comb begin
      st_nxt  = st_r;
      baud    = st_r.ctl.rclk | st_r.ctl.tx_clock_select;
      capMode = st_r.ctl.timer2_capture_select & ~baud;
      inc     = st_r.ctl.tr2 & (st_r.ctl.timer2_counter_select ? cntFall : 1'b1);
      extEv   = st_r.ctl.tr2 & st_r.ctl.timer2_external_enable & ~baud & trigFall;
      st_nxt.ovf = inc & (&st_r.cnt);
      // count step; overflow reloads unless capturing
      if (inc) begin
         if (&st_r.cnt) begin
            st_nxt.cnt = capMode ? `DTRT_RST_WORD : st_r.rcap;
         end else begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
         end
      end
      // trigger edge: capture the live count or force a reload
      if (extEv) begin
         if (capMode) begin
            st_nxt.rcap = st_r.cnt;
         end else begin
            st_nxt.cnt = st_r.rcap;
         end
      end
      // software writes take effect on the next clock
      if (sfrReq.wr) begin
         unique case (sfrReq.addr)
            `DTRT_ADDR_TIMER2_CONTROL: st_nxt.ctl        = sfrReq.wdata;
            `DTRT_ADDR_TL2:   st_nxt.cnt[7:0]   = sfrReq.wdata;
            `DTRT_ADDR_TH2:   st_nxt.cnt[15:8]  = sfrReq.wdata;
            `DTRT_ADDR_RCAPL: st_nxt.rcap[7:0]  = sfrReq.wdata;
            `DTRT_ADDR_RCAPH: st_nxt.rcap[15:8] = sfrReq.wdata;
            default: ;
         endcase
      end
      // hardware set wins over a software clear in the same cycle
      if (st_nxt.ovf & ~baud) begin
         st_nxt.ctl.tf2 = 1'b1;
      end
      if (extEv) begin
         st_nxt.ctl.timer2_external_flag = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign ctl      = st_r.ctl;
   assign count    = st_r.cnt;
   assign reload   = st_r.rcap;
   assign ovfPulse = st_r.ovf;

endmodule : dtrt_t2

// File: logic/dtrt_timers.sv
/*
 * Top of the timer/counter block: timers 0 and 1, register read-back and
 * serial baud tick selection; timer 2 and pin synchronisers are instantiated.
 * Assumes the core issues at most one register write per clock over sfrReq,
 * reads through sfrRdAddr with one clock of latency, and pulses the
 * acknowledge inputs when it vectors to a timer 0 or 1 service routine.
 */
`timescale 1ns/10ps
`include "dtrt_map.svh"

module dtrt_timers #(
   parameter int MC_DIV = `DTRT_CLK_PER_MC
) (
   input  logic                clk,
   input  logic                rstn,
   input  dtrt_pkg::dtrt_sfr_t sfrReq,
   input  logic [7:0]          sfrRdAddr,
   output logic [7:0]          sfrRdata,
   input  logic                timer0VectorAck,
   input  logic                timer1VectorAck,
   input  logic                extIrq0Pin,
   input  logic                extIrq1Pin,
   input  logic                timer0CountPin,
   input  logic                timer1CountPin,
   input  logic                timer2CountPin,
   input  logic                timer2TriggerPin,
   output logic                timer0OverflowFlag,
   output logic                timer1OverflowFlag,
   output logic                timer2OverflowFlag,
   output logic                timer2ExternalFlag,
   output logic                rxBaudTick,
   output logic                txBaudTick
);

   // ========================================================================
   // elaboration check on the machine-cycle divider
   if (MC_DIV < 2 || MC_DIV > 16) begin : g_bad_div
      $error("MC_DIV must lie between 2 and 16");
   end

   typedef struct packed {
      logic [3:0] mc;
      logic [7:0] timer01_control_reg;
      logic [7:0] timer01_mode_reg;
      logic [7:0] tl0;
      logic [7:0] th0;
      logic [7:0] tl1;
      logic [7:0] th1;
      logic [7:0] rdata;
      logic       rxb;
      logic       txb;
   } dtrt_top_st_t;

   localparam logic [3:0] MC_LAST = 4'(MC_DIV - 1);

   dtrt_top_st_t          st_r;
   dtrt_top_st_t          st_nxt;
   dtrt_pkg::dtrt_timer2_control_t t2Ctl;
   logic [15:0]           t2Count;
   logic [15:0]           t2Reload;
   logic                  t2Ovf;
   logic                  irq0Lvl;
   logic                  irq1Lvl;
   logic                  t0Fall;
   logic                  t1Fall;
   logic                  t2CntFall;
   logic                  t2TrigFall;

   // ========================================================================
   // pin synchronisers
   dtrt_pin_sync u_sync_irq0 (
      .clk   (clk),
      .rstn  (rstn),
      .pinIn (extIrq0Pin),
      .level (irq0Lvl),
      .fall  ()
   );

   dtrt_pin_sync u_sync_irq1 (
      .clk   (clk),
      .rstn  (rstn),
      .pinIn (extIrq1Pin),
      .level (irq1Lvl),
      .fall  ()
   );

   dtrt_pin_sync u_sync_t0 (
      .clk   (clk),
      .rstn  (rstn),
      .pinIn (timer0CountPin),
      .level (),
      .fall  (t0Fall)
   );

   dtrt_pin_sync u_sync_t1 (
      .clk   (clk),
      .rstn  (rstn),
      .pinIn (timer1CountPin),
      .level (),
      .fall  (t1Fall)
   );

   dtrt_pin_sync u_sync_t2c (
      .clk   (clk),
      .rstn  (rstn),
      .pinIn (timer2CountPin),
      .level (),
      .fall  (t2CntFall)
   );

   dtrt_pin_sync u_sync_t2t (
      .clk   (clk),
      .rstn  (rstn),
      .pinIn (timer2TriggerPin),
      .level (),
      .fall  (t2TrigFall)
   );

   // ========================================================================
   // timer 2
   dtrt_t2 u_t2 (
      .clk      (clk),
      .rstn     (rstn),
      .sfrReq   (sfrReq),
      .cntFall  (t2CntFall),
      .trigFall (t2TrigFall),
      .ctl      (t2Ctl),
      .count    (t2Count),
      .reload   (t2Reload),
      .ovfPulse (t2Ovf)
   );

   // ========================================================================
   // one counting step of a byte pair in a given mode
   function automatic dtrt_pkg::dtrt_cnt_t cnt_step(
      input dtrt_pkg::dtrt_mode_t m,
      input logic [7:0]           th,
      input logic [7:0]           tl,
      input logic                 inc
   );
      dtrt_pkg::dtrt_cnt_t r;
      r.th  = th;
      r.tl  = tl;
      r.ovf = 1'b0;
      if (inc) begin
         unique case (m)
            dtrt_pkg::DTRT_M13: begin
               // upper three low-byte bits are left as they are
               {r.th, r.tl[4:0]} = {th, tl[4:0]} + 13'h0001;
               r.ovf             = &{th, tl[4:0]};
            end
            dtrt_pkg::DTRT_M16: begin
               {r.th, r.tl} = {th, tl} + 16'h0001;
               r.ovf        = &{th, tl};
            end
            dtrt_pkg::DTRT_M8R: begin
               if (&tl) begin
                  r.tl  = th;
                  r.ovf = 1'b1;
               end else begin
                  r.tl = tl + 8'h01;
               end
            end
            dtrt_pkg::DTRT_MSPL: ; // split or held: handled by the caller
         endcase
      end
      return r;
   endfunction : cnt_step

   // ========================================================================
   // timers 0 and 1, flags, register writes, read-back and baud ticks
   always_comb begin
      dtrt_pkg::dtrt_mode_t m0;
      dtrt_pkg::dtrt_mode_t m1;
      dtrt_pkg::dtrt_cnt_t  c0;
      dtrt_pkg::dtrt_cnt_t  c1;
      logic                 tick;
      logic                 split;
      logic                 inc0;
      logic                 inc1;
      logic                 ovf0;
      logic                 ovf1;
      logic [7:0]           timer01_control_reg;
      // locals start from known values on every pass
      m0     = dtrt_pkg::DTRT_M13;
      m1     = dtrt_pkg::DTRT_M13;
      c0     = '0;
      c1     = '0;
      tick   = 1'b0;
      split  = 1'b0;
      inc0   = 1'b0;
      inc1   = 1'b0;
      ovf0   = 1'b0;
      ovf1   = 1'b0;
      timer01_control_reg   = 8'h00;
      st_nxt = st_r;
      m0     = dtrt_pkg::dtrt_mode_t'(st_r.timer01_mode_reg[`DTRT_TIMER01_MODE_REG_MODE_LSB +: 2]);
      m1     = dtrt_pkg::dtrt_mode_t'(st_r.timer01_mode_reg[`DTRT_TIMER01_MODE_REG_T1_LSB +: 2]);
      split  = (m0 == dtrt_pkg::DTRT_MSPL);
      // machine-cycle prescaler
      tick      = (st_r.mc == MC_LAST);
      st_nxt.mc = tick ? 4'h0 : st_r.mc + 4'h1;
      // timer 0 count input: pin edges or machine cycles, gated
      inc0 = st_r.timer01_control_reg[`DTRT_TIMER01_CONTROL_REG_TR0]
           & (~st_r.timer01_mode_reg[`DTRT_TIMER01_MODE_REG_GATE] | irq0Lvl)
           & (st_r.timer01_mode_reg[`DTRT_TIMER01_MODE_REG_CT] ? t0Fall : tick);
      c0 = cnt_step(m0, st_r.th0, st_r.tl0, inc0 & ~split);
      ovf0 = c0.ovf;
      if (split) begin
         // low byte on timer 0 controls, high byte on timer 1 run bit
         c0.tl = st_r.tl0 + {7'h00, inc0};
         ovf0  = inc0 & (&st_r.tl0);
         c0.th = st_r.th0 + {7'h00, tick & st_r.timer01_control_reg[`DTRT_TIMER01_CONTROL_REG_TR1]};
      end
      // timer 1: with timer 0 split, TR1 is ignored; mode 3 starts and stops it
      inc1 = (split ? 1'b1 : st_r.timer01_control_reg[`DTRT_TIMER01_CONTROL_REG_TR1])
           & (~st_r.timer01_mode_reg[`DTRT_TIMER01_MODE_REG_T1_LSB + `DTRT_TIMER01_MODE_REG_GATE] | irq1Lvl)
           & (st_r.timer01_mode_reg[`DTRT_TIMER01_MODE_REG_T1_LSB + `DTRT_TIMER01_MODE_REG_CT] ? t1Fall : tick)
           & (m1 != dtrt_pkg::DTRT_MSPL);
      c1 = cnt_step(m1, st_r.th1, st_r.tl1, inc1);
      ovf1 = split ? (tick & st_r.timer01_control_reg[`DTRT_TIMER01_CONTROL_REG_TR1] & (&st_r.th0)) : c1.ovf;
      // counts move only by counting or by their own writes; run writes never touch them
      st_nxt.tl0 = c0.tl;
      st_nxt.th0 = c0.th;
      st_nxt.tl1 = c1.tl;
      st_nxt.th1 = c1.th;
      timer01_control_reg       = st_r.timer01_control_reg;
      // software writes take effect on the next clock and beat counting
      if (sfrReq.wr) begin
         unique case (sfrReq.addr)
            `DTRT_ADDR_TIMER01_CONTROL_REG: timer01_control_reg        = sfrReq.wdata;
            `DTRT_ADDR_TIMER01_MODE_REG: st_nxt.timer01_mode_reg = sfrReq.wdata;
            `DTRT_ADDR_TL0:  st_nxt.tl0  = sfrReq.wdata;
            `DTRT_ADDR_TH0:  st_nxt.th0  = sfrReq.wdata;
            `DTRT_ADDR_TL1:  st_nxt.tl1  = sfrReq.wdata;
            `DTRT_ADDR_TH1:  st_nxt.th1  = sfrReq.wdata;
            default: ;
         endcase
      end
      // vector acknowledge clears, a same-cycle overflow still sets
      if (timer0VectorAck) begin
         timer01_control_reg[`DTRT_TIMER01_CONTROL_REG_TF0] = 1'b0;
      end
      if (timer1VectorAck) begin
         timer01_control_reg[`DTRT_TIMER01_CONTROL_REG_TF1] = 1'b0;
      end
      timer01_control_reg[`DTRT_TIMER01_CONTROL_REG_TF0] = timer01_control_reg[`DTRT_TIMER01_CONTROL_REG_TF0] | ovf0;
      timer01_control_reg[`DTRT_TIMER01_CONTROL_REG_TF1] = timer01_control_reg[`DTRT_TIMER01_CONTROL_REG_TF1] | ovf1;
      st_nxt.timer01_control_reg          = timer01_control_reg;
      // baud sources: timer 1 overflow keeps flowing even when split
      st_nxt.rxb = t2Ctl.rclk ? t2Ovf : c1.ovf;
      st_nxt.txb = t2Ctl.tx_clock_select ? t2Ovf : c1.ovf;
      // registered read-back of the addressed register
      unique case (sfrRdAddr)
         `DTRT_ADDR_TIMER01_CONTROL_REG:  st_nxt.rdata = st_r.timer01_control_reg;
         `DTRT_ADDR_TIMER01_MODE_REG:  st_nxt.rdata = st_r.timer01_mode_reg;
         `DTRT_ADDR_TL0:   st_nxt.rdata = st_r.tl0;
         `DTRT_ADDR_TH0:   st_nxt.rdata = st_r.th0;
         `DTRT_ADDR_TL1:   st_nxt.rdata = st_r.tl1;
         `DTRT_ADDR_TH1:   st_nxt.rdata = st_r.th1;
         `DTRT_ADDR_TIMER2_CONTROL: st_nxt.rdata = t2Ctl;
         `DTRT_ADDR_RCAPL: st_nxt.rdata = t2Reload[7:0];
         `DTRT_ADDR_RCAPH: st_nxt.rdata = t2Reload[15:8];
         `DTRT_ADDR_TL2:   st_nxt.rdata = t2Count[7:0];
         `DTRT_ADDR_TH2:   st_nxt.rdata = t2Count[15:8];
         default:          st_nxt.rdata = `DTRT_RST_BYTE;
      endcase
   end

   // ========================================================================
   // state register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ========================================================================
   // outputs, all from flops
   assign sfrRdata           = st_r.rdata;
   assign timer0OverflowFlag = st_r.timer01_control_reg[`DTRT_TIMER01_CONTROL_REG_TF0];
   assign timer1OverflowFlag = st_r.timer01_control_reg[`DTRT_TIMER01_CONTROL_REG_TF1];
   assign timer2OverflowFlag = t2Ctl.tf2;
   assign timer2ExternalFlag = t2Ctl.timer2_external_flag;
   assign rxBaudTick         = st_r.rxb;
   assign txBaudTick         = st_r.txb;

endmodule : dtrt_timers

// File: dv/dtrt_timers_checker.sv
/* port assertions for the timer block
   assumes the bind below attaches it to every dtrt_timers */
`timescale 1ns/10ps
module dtrt_timers_checker (
   input logic                clk,
   input logic                rstn,
   input dtrt_pkg::dtrt_sfr_t sfrReq,
   input logic [7:0]          sfrRdAddr,
   input logic [7:0]          sfrRdata,
   input logic                timer0VectorAck,
   input logic                timer2TriggerPin,
   input logic                timer0OverflowFlag,
   input logic                timer1OverflowFlag,
   input logic                timer2OverflowFlag,
   input logic                timer2ExternalFlag
);
   // ======================================================================
   // helper: control writes and the serial clock selects of timer 2
   logic       wrT2;
   logic       wrTcon;
   logic [1:0] serSel_r;
   assign wrT2   = sfrReq.wr && sfrReq.addr == 8'hC8;
   assign wrTcon = sfrReq.wr && sfrReq.addr == 8'h88;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) serSel_r <= 2'h0;
      else if (wrT2) serSel_r <= sfrReq.wdata[5:4];
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // ======================================================================
   // write then read of the reload high byte
   sequence wr_then_rd;
      (sfrReq.wr && sfrReq.addr == 8'hCB) ##1 (sfrRdAddr == 8'hCB);
   endsequence
   chk_unmapped_zero: assert property (!(sfrRdAddr inside {8'h88, 8'h89, 8'h8A, 8'h8B,
      8'h8C, 8'h8D, 8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD}) |=> sfrRdata == 8'h00)
      else $error("unmapped read not zero");
   chk_reload_readback: assert property (wr_then_rd |=> sfrRdata == $past(sfrReq.wdata, 2))
      else $error("reload byte read back wrong");
   chk_baud_no_tf2: assert property (serSel_r != 2'h0 && !wrT2 |=> !$rose(timer2OverflowFlag))
      else $error("timer 2 flag set in baud mode");
   chk_tf2_sticky: assert property (timer2OverflowFlag && !wrT2 |=> timer2OverflowFlag)
      else $error("timer 2 overflow flag lost");
   chk_timer2_external_flag_sticky: assert property (timer2ExternalFlag && !wrT2 |=> timer2ExternalFlag)
      else $error("timer 2 external flag lost");
   chk_timer2_external_flag_cause: assert property ($rose(timer2ExternalFlag) && !$past(wrT2) |->
      (!$past(timer2TriggerPin, 2) || !$past(timer2TriggerPin, 3) ||
       !$past(timer2TriggerPin, 4) || !$past(timer2TriggerPin, 5)))
      else $error("external flag without trigger edge");
   chk_tf0_sticky: assert property (timer0OverflowFlag && !timer0VectorAck && !wrTcon
      |=> timer0OverflowFlag)
      else $error("timer 0 flag lost");
   chk_ack_clears: assert property (timer0VectorAck |-> ##[1:2] !timer0OverflowFlag)
      else $error("ack did not clear timer 0 flag");
   chk_timer2_control_read: assert property (sfrRdAddr == 8'hC8 |=>
      sfrRdata[7:6] == {$past(timer2OverflowFlag), $past(timer2ExternalFlag)})
      else $error("timer 2 control flags read wrong");
   chk_timer01_control_reg_read: assert property (sfrRdAddr == 8'h88 |=>
      {sfrRdata[7], sfrRdata[5]} == {$past(timer1OverflowFlag), $past(timer0OverflowFlag)})
      else $error("timer 0/1 flags read wrong");
endmodule : dtrt_timers_checker

bind dtrt_timers dtrt_timers_checker chk (.clk(clk), .rstn(rstn), .sfrReq(sfrReq),
   .sfrRdAddr(sfrRdAddr), .sfrRdata(sfrRdata), .timer0VectorAck(timer0VectorAck),
   .timer2TriggerPin(timer2TriggerPin), .timer0OverflowFlag(timer0OverflowFlag),
   .timer1OverflowFlag(timer1OverflowFlag), .timer2OverflowFlag(timer2OverflowFlag),
   .timer2ExternalFlag(timer2ExternalFlag));

// File: dv/dtrt_core_model.sv
/* core side model: register writes, reads and vector acknowledge
   assumes callers run one task at a time, just after a rising edge */
`timescale 1ns/10ps
module dtrt_core_model (
   input  logic                clk,
   input  logic [7:0]          sfrRdata,
   output dtrt_pkg::dtrt_sfr_t sfrReq,
   output logic [7:0]          sfrRdAddr,
   output logic                timer0VectorAck
);
   // ======================================================================
   // idle bus at time zero
   initial begin
      sfrReq          = '{wr: 1'b0, addr: 8'h00, wdata: 8'h00};
      sfrRdAddr       = 8'h00;
      timer0VectorAck = 1'b0;
   end
   // one write, held over the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      sfrReq = '{wr: 1'b1, addr: a, wdata: d};
      @(posedge clk);
      #1;
      sfrReq.wr = 1'b0;
   endtask : wr
   // address now, data after the next edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      sfrRdAddr = a;
      @(posedge clk);
      #1;
      d = sfrRdata;
   endtask : rd
   // one cycle vector acknowledge for timer 0
   task automatic ack0;
      timer0VectorAck = 1'b1;
      @(posedge clk);
      #1;
      timer0VectorAck = 1'b0;
   endtask : ack0
endmodule : dtrt_core_model

// File: dv/dtrt_timers_test.sv
/* self-checking bench for the timer block
   assumes the checker is bound by its own file; short machine cycle */
`timescale 1ns/10ps
module dtrt_timers_test;
   logic                clk, rstn, ext0, cnt0, trig, rxTick, txTick;
   logic                tf0, tf1, tf2, timer2_external_flag;
   logic [7:0]          rdAddr, rdata, v;
   logic [5:0]          flags;
   dtrt_pkg::dtrt_sfr_t sfrReq;
   logic                ack0;
   int                  nFail, cmpCount, cyc;
   assign flags = {txTick, rxTick, timer2_external_flag, tf2, tf1, tf0};
   dtrt_timers #(.MC_DIV(2)) uut (.clk(clk), .rstn(rstn), .sfrReq(sfrReq),
      .sfrRdAddr(rdAddr), .sfrRdata(rdata), .timer0VectorAck(ack0),
      .timer1VectorAck(1'b0), .extIrq0Pin(ext0), .extIrq1Pin(1'b1),
      .timer0CountPin(cnt0), .timer1CountPin(1'b1), .timer2CountPin(1'b1),
      .timer2TriggerPin(trig), .timer0OverflowFlag(tf0), .timer1OverflowFlag(tf1),
      .timer2OverflowFlag(tf2), .timer2ExternalFlag(timer2_external_flag), .rxBaudTick(rxTick),
      .txBaudTick(txTick));
   dtrt_core_model core (.clk(clk), .sfrRdata(rdata), .sfrReq(sfrReq),
      .sfrRdAddr(rdAddr), .timer0VectorAck(ack0));
   // ======================================================================
   // clock and hang guard
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         nFail++;
         give_verdict();
      end
   end
   // ======================================================================
   // compares, waits and verdict
   task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
      cmpCount++;
      if (g !== e) begin
         nFail++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : cmp8
   task automatic cmp1(input string n, input logic e, input logic g);
      cmpCount++;
      if (g !== e) begin
         nFail++;
         $display("[ERR] %s expected %b seen %b", n, e, g);
      end
   endtask : cmp1
   task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
      core.rd(a, v);
      cmp8($sformatf("reg %h", a), e, v);
   endtask : rdChk
   task automatic waitBit(input int i);
      int n;
      n = 0;
      while (flags[i] !== 1'b1 && n < 30) begin
         @(posedge clk);
         #1;
         n++;
      end
      cmp1($sformatf("flag %0d", i), 1'b1, flags[i]);
   endtask : waitBit
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : idle
   task automatic give_verdict;
      if (nFail == 0 && cmpCount > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : give_verdict
   // ======================================================================
   // main sequence
   initial begin
      logic [7:0] regs [12];
      regs = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'h8E};
      {rstn, ext0, cnt0, trig, nFail, cmpCount, cyc} = '0;
      {ext0, cnt0, trig} = 3'h7;
      idle(12);
      rstn = 1'b1;
      foreach (regs[i]) rdChk(regs[i], 8'h00);
      core.wr(8'hCB, 8'h5A);
      rdChk(8'hCB, 8'h5A);
      // mode 0, then flag clear by acknowledge
      core.wr(8'h89, 8'h00);
      core.wr(8'h8C, 8'hFF);
      core.wr(8'h8A, 8'h1F);
      core.wr(8'h88, 8'h10);
      waitBit(0);
      rdChk(8'h8C, 8'h00);
      rdChk(8'h88, 8'h30);
      core.ack0();
      cmp1("tf0", 1'b0, tf0);
      // modes 1 and 2, gate and counter select over a table
      for (int m = 0; m < 4; m++) begin
         core.wr(8'h88, 8'h00);
         core.wr(8'h89, m == 0 ? 8'h01 : m == 1 ? 8'h02 : m == 2 ? 8'h09 : 8'h05);
         core.wr(8'h8C, m == 1 ? 8'hA5 : 8'hFF);
         core.wr(8'h8A, 8'hFF);
         if (m == 2) ext0 = 1'b0;
         core.wr(8'h88, 8'h10);
         if (m >= 2) begin
            idle(20);
            cmp1("tf0 held", 1'b0, tf0);
            ext0 = 1'b1;
            cnt0 = 1'b0;
         end
         waitBit(0);
         cnt0 = 1'b1;
         rdChk(8'h8C, m == 1 ? 8'hA5 : 8'h00);
      end
      // timer 1 held in mode 3, then baud source with timer 0 split
      core.wr(8'h89, 8'h30);
      core.wr(8'h88, 8'h40);
      core.wr(8'h8B, 8'hFF);
      core.wr(8'h8D, 8'hFF);
      idle(20);
      cmp1("tf1", 1'b0, tf1);
      rdChk(8'h8B, 8'hFF);
      core.wr(8'h89, 8'h23);
      waitBit(4);
      // timer 2 auto-reload on overflow
      core.wr(8'h88, 8'h00);
      core.wr(8'hCB, 8'h12);
      core.wr(8'hCA, 8'h34);
      core.wr(8'hCD, 8'hFF);
      core.wr(8'hCC, 8'hFE);
      rdChk(8'hCC, 8'hFE);
      core.wr(8'hC8, 8'h04);
      waitBit(2);
      core.wr(8'hC8, 8'h80);
      rdChk(8'hCD, 8'h12);
      rdChk(8'hC8, 8'h80);
      // baud mode: ticks both ways, no overflow flag
      core.wr(8'hC8, 8'h00);
      core.wr(8'hCB, 8'hFF);
      core.wr(8'hCA, 8'hF0);
      core.wr(8'hCD, 8'hFF);
      core.wr(8'hCC, 8'hF0);
      core.wr(8'hC8, 8'h34);
      waitBit(5);
      waitBit(4);
      idle(40);
      cmp1("tf2", 1'b0, tf2);
      // trigger edge: reload, then capture, then ignored
      for (int m = 0; m < 3; m++) begin
         core.wr(8'hC8, 8'h00);
         core.wr(8'hCB, 8'hAB);
         core.wr(8'hCD, m == 1 ? 8'h77 : 8'h00);
         core.wr(8'hCC, 8'h00);
         core.wr(8'hC8, m == 0 ? 8'h0C : m == 1 ? 8'h0D : 8'h04);
         trig = 1'b0;
         if (m < 2) waitBit(3);
         else idle(10);
         trig = 1'b1;
         if (m == 2) cmp1("timer2_external_flag", 1'b0, timer2_external_flag);
         else rdChk(m == 0 ? 8'hCD : 8'hCB, m == 0 ? 8'hAB : 8'h77);
      end
      give_verdict();
   end
endmodule : dtrt_timers_test
